/* shared/pecl_pkg.sv */
// Shared constants, types and register map for the link event counter log.
package pecl_pkg;

	// Counter bank size and reported field layout.
	localparam int              PECL_NCNT      = 8;
	localparam int              PECL_FIELD_W   = 32;
	localparam logic [3:0]      PECL_NCNT_4    = 4'h8;
	localparam logic [8:0]      PECL_HDR_BYTES = 9'h004;
	localparam logic [8:0]      PECL_LAST_BYTE = 9'h1FF;
	localparam logic [2:0]      PECL_ID_BYTES  = 3'h2;
	localparam logic [2:0]      PECL_ENT_LAST  = 3'h5;
	localparam logic [1:0]      PECL_WORD_LAST = 2'h3;
	localparam int              PECL_PAGE_AW   = 7;

	// Entry identifiers, width code 2h (32-bit value) in bits 14:12.
	localparam logic [PECL_NCNT-1:0][15:0] PECL_IDS = {
		16'h200D, 16'h200B, 16'h200A, 16'h2009,
		16'h2007, 16'h2006, 16'h2005, 16'h2004
	};

	// Counter slots, in the order of the identifier table.
	localparam int PECL_C_H2D_DATA = 0;
	localparam int PECL_C_ND_BOTH  = 1;
	localparam int PECL_C_D2H_ND   = 2;
	localparam int PECL_C_H2D_ND   = 3;
	localparam int PECL_C_LINK_UP  = 4;
	localparam int PECL_C_SIG_ROK  = 5;
	localparam int PECL_C_H2D_CRC  = 6;
	localparam int PECL_C_H2D_OTH  = 7;

	// APB register map, byte addresses.
	localparam int          PECL_AW        = 12;
	localparam logic [11:0] PECL_A_CTRL    = 12'h000;
	localparam logic [11:0] PECL_A_STAT    = 12'h004;
	localparam logic [11:0] PECL_A_CNT     = 12'h020;
	localparam logic [11:0] PECL_A_PAGE    = 12'h200;

	// Control and status bit positions.
	localparam int PECL_CTRL_BUILD  = 0;
	localparam int PECL_CTRL_CLR_RD = 1;
	localparam int PECL_CTRL_CLR    = 2;
	localparam int PECL_STAT_BUSY   = 0;
	localparam int PECL_STAT_VALID  = 1;

	// Link layer events, each a one-cycle pulse with its qualifiers.
	typedef struct packed {
		logic h2d_rerr;
		logic h2d_data;
		logic h2d_crc;
		logic d2h_nd_rerr;
		logic sig_rok;
	} pecl_evt_s;

	typedef enum logic [1:0] {
		PECL_ST_IDLE = 2'b01,
		PECL_ST_FILL = 2'b10
	} pecl_state_e;

endpackage : pecl_pkg

/* src/pecl_log_ram.sv */
// Page memory for the log: one write port, one registered read port.
`timescale 1ns/1ps
module pecl_log_ram #(
	parameter int AW = 7,
	parameter int DW = 32
) (
	input  wire logic          CLK_SYS,
	input  wire logic          WE,
	input  wire logic [AW-1:0] WADDR,
	input  wire logic [DW-1:0] WDATA,
	input  wire logic [AW-1:0] RADDR,
	output logic      [DW-1:0] RDATA
);

	logic [DW-1:0] mem_ff [2**AW];
	logic [DW-1:0] rdata_ff;

	// Write port, driven by the page builder only.
	always_ff @(posedge CLK_SYS) begin
		if (WE) begin
			mem_ff[WADDR] <= WDATA;
		end
	end

	// Read data comes out of a register, one cycle after the address.
	always_ff @(posedge CLK_SYS) begin
		rdata_ff <= mem_ff[RADDR];
	end

	assign RDATA = rdata_ff;

endmodule : pecl_log_ram

/* src/pecl_counter_log.sv */
// Link event counter bank with counter log page builder and APB slave.
//
// Function
// - Count received data frames answered with R_ERR.
// - Count non-data R_ERR both directions together, every retry counted.
// - Count transmitted non-data frames the host answered with R_ERR.
// - Count received non-data frames the device answered with R_ERR.
// - Count every move from link down to link up, any cause.
// - Power management caused link up moves may also be counted.
// - Count reset signature frames after COMRESET acknowledged with R_OK.
// - Count received frames rejected with R_ERR for CRC failure.
// - Count received frames rejected with R_ERR for other causes.
// - Page is exactly 512 bytes; first word is reserved header.
// - Entry list ends with a zero identifier; nothing follows it.
// - Each entry starts with a 16-bit identifier.
// - Identifier bits 14:12 give value width, multiple of 16 bits.
// - A saturated narrow counter reports all higher bits as ones.
// - Counters saturate and hold, never wrap.
// - Last byte makes the byte sum of all 512 bytes zero.
// - Reserved bytes, header and padding, are zero.
// - BIST activation resets all counters.
// - Log read with clear flag snapshots values, then resets counters.
// - Of the resets, only power-on reset clears counters; link resets do not.
// - Width code 2h marks 32-bit values; bit 15 stays clear.
`timescale 1ns/1ps
module pecl_counter_log import pecl_pkg::*; #(
	parameter int CNT_W = 16
) (
	input  wire logic               CLK_SYS,
	input  wire logic               RSTN,
	input  wire logic [PECL_AW-1:0] PADDR,
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [31:0]        PWDATA,
	output logic      [31:0]        PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR,
	input  wire pecl_evt_s          EVT,
	input  wire logic               LINK_UP,
	input  wire logic               BIST_ACT,
	input  wire logic               LOG_REQ,
	input  wire logic               LOG_CLR,
	output logic                    LOG_BUSY,
	output logic                    LOG_DONE
);

	// The one-extension scheme needs the counter to fit the field.
	// Wider or empty counters are refused when the design is
	// elaborated, before any logic is built from them.
	if (CNT_W < 1 || CNT_W > PECL_FIELD_W) begin : g_cnt_w_bad
		$error("CNT_W must lie between 1 and the field width.");
	end

	// Add a small increment and stick at all ones instead of wrapping.
	function automatic logic [CNT_W-1:0] sat_add(
		input logic [CNT_W-1:0] a,
		input logic [1:0]       d
	);
		logic [CNT_W:0] s;
		s = {1'b0, a} + (CNT_W+1)'(d);
		return s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
	endfunction : sat_add

	// Widen a count to the reported field, one-extended once saturated.
	function automatic logic [PECL_FIELD_W-1:0] rep_val(
		input logic [CNT_W-1:0] c
	);
		logic [PECL_FIELD_W-1:0] v;
		v = PECL_FIELD_W'(c);
		if (&c) begin
			v = {PECL_FIELD_W{1'b1}};
		end
		return v;
	endfunction : rep_val

	logic [CNT_W-1:0]    cnt_ff  [PECL_NCNT];
	logic [CNT_W-1:0]    snap_ff [PECL_NCNT];
	logic [CNT_W-1:0]    nxt_cnt [PECL_NCNT];
	logic [1:0]          inc     [PECL_NCNT];
	logic                link_up_ff;
	logic                clr_rd_ff;
	logic                valid_ff;
	logic                busy_ff;
	logic                done_ff;
	pecl_state_e         st_ff;
	logic [8:0]          byte_ff;
	logic [3:0]          ent_ff;
	logic [2:0]          off_ff;
	logic [7:0]          sum_ff;
	logic [23:0]         wbuf_ff;
	logic [7:0]          cur_byte;
	logic                in_list;
	logic                ram_we;
	logic [31:0]         ram_wdata;
	logic [31:0]         ram_rdata;
	logic                wait_ff;
	logic                pready_ff;
	logic                pslverr_ff;
	logic [31:0]         prdata_ff;
	logic                access;
	logic                apb_wr;
	logic                hit_ctrl;
	logic                hit_stat;
	logic                hit_cnt;
	logic                hit_page;
	logic                rd_err;
	logic                wr_err;
	logic [31:0]         rd_data;
	logic                sw_build;
	logic                sw_clr;
	logic                start;
	logic                clr_now;
	logic                link_rise;

	// Event decode into per-counter increments of zero, one or two.
	always_comb begin
		for (int i = 0; i < PECL_NCNT; i++) begin
			inc[i] = 2'h0;
		end
		inc[PECL_C_H2D_DATA] = {1'b0, EVT.h2d_rerr & EVT.h2d_data};
		inc[PECL_C_H2D_ND]   = {1'b0, EVT.h2d_rerr & ~EVT.h2d_data};
		inc[PECL_C_D2H_ND]   = {1'b0, EVT.d2h_nd_rerr};
		// Both directions may fail in one cycle, so this one can add two.
		inc[PECL_C_ND_BOTH]  = inc[PECL_C_H2D_ND] + inc[PECL_C_D2H_ND];
		// Every link up edge counts; power management edges included.
		inc[PECL_C_LINK_UP]  = {1'b0, link_rise};
		inc[PECL_C_SIG_ROK]  = {1'b0, EVT.sig_rok};
		inc[PECL_C_H2D_CRC]  = {1'b0, EVT.h2d_rerr & EVT.h2d_crc};
		inc[PECL_C_H2D_OTH]  = {1'b0, EVT.h2d_rerr & ~EVT.h2d_crc};
	end

	// Remember the link level to find the down-to-up transition.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			link_up_ff <= 1'b0;
		end else begin
			link_up_ff <= LINK_UP;
		end
	end

	assign link_rise = LINK_UP & ~link_up_ff;

	// A log request is taken only while the builder is idle.
	assign start   = (LOG_REQ | sw_build) & (st_ff == PECL_ST_IDLE);
	assign clr_now = BIST_ACT | sw_clr
		| (start & (LOG_REQ ? LOG_CLR : clr_rd_ff));

	// Next counts: a clear restarts from zero, but an event in the
	// same cycle still lands, so nothing is lost across a clear.
	always_comb begin
		for (int i = 0; i < PECL_NCNT; i++) begin
			nxt_cnt[i] = sat_add(clr_now ? '0 : cnt_ff[i], inc[i]);
		end
	end

	// Counter bank; RSTN is the power-on reset, link resets never
	// reach this block.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			for (int i = 0; i < PECL_NCNT; i++) begin
				cnt_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < PECL_NCNT; i++) begin
				cnt_ff[i] <= nxt_cnt[i];
			end
		end
	end

	// Snapshot is taken before the clear so the page shows old values.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			for (int i = 0; i < PECL_NCNT; i++) begin
				snap_ff[i] <= '0;
			end
		end else if (start) begin
			for (int i = 0; i < PECL_NCNT; i++) begin
				snap_ff[i] <= cnt_ff[i];
			end
		end
	end

	// Current page byte: header, packed entries, zero fill, checksum.
	assign in_list = (byte_ff >= PECL_HDR_BYTES)
		& (ent_ff < PECL_NCNT_4);

	always_comb begin
		logic [15:0]             id;
		logic [PECL_FIELD_W-1:0] val;
		id       = PECL_IDS[ent_ff[2:0]];
		val      = rep_val(snap_ff[ent_ff[2:0]]);
		cur_byte = 8'h00;
		if (byte_ff == PECL_LAST_BYTE) begin
			cur_byte = 8'h00 - sum_ff;
		end else if (in_list) begin
			if (off_ff < PECL_ID_BYTES) begin
				cur_byte = id[off_ff[0]*8 +: 8];
			end else begin
				cur_byte = val[(off_ff - PECL_ID_BYTES)*8 +: 8];
			end
		end
	end

	// After the last entry the index sits at the count, so the bytes
	// that follow are zero and read as the end marker.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			ent_ff <= 4'h0;
			off_ff <= 3'h0;
		end else if (start) begin
			ent_ff <= 4'h0;
			off_ff <= 3'h0;
		end else if (st_ff == PECL_ST_FILL && in_list) begin
			if (off_ff == PECL_ENT_LAST) begin
				off_ff <= 3'h0;
				ent_ff <= ent_ff + 4'h1;
			end else begin
				off_ff <= off_ff + 3'h1;
			end
		end
	end

	// Byte walk over the whole page and running byte sum.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			byte_ff <= 9'h000;
			sum_ff  <= 8'h00;
			wbuf_ff <= 24'h00_0000;
		end else if (start) begin
			byte_ff <= 9'h000;
			sum_ff  <= 8'h00;
			wbuf_ff <= 24'h00_0000;
		end else if (st_ff == PECL_ST_FILL) begin
			byte_ff <= byte_ff + 9'h001;
			sum_ff  <= sum_ff + cur_byte;
			case (byte_ff[1:0])
				2'h0: wbuf_ff[7:0]   <= cur_byte;
				2'h1: wbuf_ff[15:8]  <= cur_byte;
				2'h2: wbuf_ff[23:16] <= cur_byte;
				default: wbuf_ff <= wbuf_ff;
			endcase
		end
	end

	// A word is written when its fourth byte is ready; byte 0 is low.
	assign ram_we    = (st_ff == PECL_ST_FILL)
		& (byte_ff[1:0] == PECL_WORD_LAST);
	assign ram_wdata = {cur_byte, wbuf_ff};

	// Builder state: fill runs 512 cycles, then the page is valid.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			st_ff    <= PECL_ST_IDLE;
			busy_ff  <= 1'b0;
			done_ff  <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (st_ff)
				PECL_ST_IDLE: begin
					if (start) begin
						st_ff    <= PECL_ST_FILL;
						busy_ff  <= 1'b1;
						valid_ff <= 1'b0;
					end
				end
				PECL_ST_FILL: begin
					if (byte_ff == PECL_LAST_BYTE) begin
						st_ff    <= PECL_ST_IDLE;
						busy_ff  <= 1'b0;
						done_ff  <= 1'b1;
						valid_ff <= 1'b1;
					end
				end
				default: begin
					st_ff   <= PECL_ST_IDLE;
					busy_ff <= 1'b0;
				end
			endcase
		end
	end

	pecl_log_ram #(
		.AW (PECL_PAGE_AW),
		.DW (32)
	) u_ram (
		.CLK_SYS (CLK_SYS),
		.WE      (ram_we),
		.WADDR   (byte_ff[8:2]),
		.WDATA   (ram_wdata),
		.RADDR   (PADDR[8:2]),
		.RDATA   (ram_rdata)
	);

	// Address decode; only aligned word accesses are mapped.
	assign hit_ctrl = (PADDR == PECL_A_CTRL);
	assign hit_stat = (PADDR == PECL_A_STAT);
	assign hit_cnt  = (PADDR[11:5] == PECL_A_CNT[11:5])
		& (PADDR[1:0] == 2'h0);
	assign hit_page = (PADDR[11:9] == PECL_A_PAGE[11:9])
		& (PADDR[1:0] == 2'h0);

	// The page is refused while it is being rebuilt.
	assign rd_err = ~(hit_ctrl | hit_stat | hit_cnt | hit_page)
		| (hit_page & busy_ff);
	assign wr_err = ~(hit_ctrl | hit_stat);

	// Read data mux; the page word arrives from the RAM register.
	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_data[PECL_CTRL_CLR_RD] = clr_rd_ff;
		end else if (hit_stat) begin
			rd_data[PECL_STAT_BUSY]  = busy_ff;
			rd_data[PECL_STAT_VALID] = valid_ff;
		end else if (hit_cnt) begin
			rd_data = 32'(cnt_ff[PADDR[4:2]]);
		end else if (hit_page && !busy_ff) begin
			rd_data = ram_rdata;
		end
	end

	// Two wait cycles on every access: the first lets the RAM answer,
	// the second registers data and ready, so all outputs are flops.
	assign access = PSEL & PENABLE;

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			wait_ff    <= 1'b0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else if (pready_ff) begin
			wait_ff    <= 1'b0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else if (access) begin
			if (!wait_ff) begin
				wait_ff <= 1'b1;
			end else begin
				pready_ff  <= 1'b1;
				pslverr_ff <= PWRITE ? wr_err : rd_err;
				prdata_ff  <= PWRITE ? 32'h0000_0000 : rd_data;
			end
		end
	end

	// Writes land at the completing edge, and not at all on error.
	assign apb_wr   = access & pready_ff & PWRITE & ~pslverr_ff;
	assign sw_build = apb_wr & hit_ctrl & PWDATA[PECL_CTRL_BUILD];
	assign sw_clr   = apb_wr & hit_ctrl & PWDATA[PECL_CTRL_CLR];

	// Stored clear-after-read choice for software-started builds.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			clr_rd_ff <= 1'b0;
		end else if (apb_wr && hit_ctrl) begin
			clr_rd_ff <= PWDATA[PECL_CTRL_CLR_RD];
		end
	end

	assign PRDATA   = prdata_ff;
	assign PREADY   = pready_ff;
	assign PSLVERR  = pslverr_ff;
	assign LOG_BUSY = busy_ff;
	assign LOG_DONE = done_ff;

endmodule : pecl_counter_log

/* sim/pecl_counter_log_sva.sv */
// Port checker for the link event counter log.
`timescale 1ns/1ps
module pecl_chk import pecl_pkg::*; (
	input wire logic        CLK_SYS,
	input wire logic        RSTN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        LOG_REQ,
	input wire logic        LOG_BUSY,
	input wire logic        LOG_DONE
);
	logic [9:0] bcnt_ff;

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	// Busy run length; a plain repetition cannot reach 512 cycles.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN || !LOG_BUSY) bcnt_ff <= 10'h000;
		else bcnt_ff <= bcnt_ff + 10'h001;
	end

	a_ready_time: assert property ($rose(PSEL && PENABLE) |-> ##2 PREADY)
		else $error("Access not answered on its third cycle.");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("Ready held longer than one cycle.");
	a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
		else $error("Read data not zero outside completion.");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("Slave error without ready.");
	a_done_len: assert property (LOG_DONE |-> bcnt_ff == 10'h200)
		else $error("Page build not 512 cycles long.");
	a_busy_end: assert property ($fell(LOG_BUSY) |-> LOG_DONE)
		else $error("Busy fell without done.");
	a_req_start: assert property (LOG_REQ && !LOG_BUSY |=> LOG_BUSY)
		else $error("Build request did not start a build.");
	a_busy_cap: assert property (LOG_BUSY |-> bcnt_ff < 10'h200)
		else $error("Busy ran past 512 cycles.");
endmodule : pecl_chk

/* sim/pecl_host_model.sv */
// Behavioural host side: frame outcomes, link drops and BIST requests.
`timescale 1ns/1ps
module pecl_host_model import pecl_pkg::*; (
	input  wire logic      CLK_SYS,
	input  wire logic      RSTN,
	input  wire logic      SEND,
	input  wire pecl_evt_s FRAME,
	input  wire logic      BIST,
	input  wire logic      RELINK,
	output pecl_evt_s      EVT,
	output logic           LINK_UP,
	output logic           BIST_ACT
);
	logic [1:0] down_ff;

	// Each frame outcome and BIST request follows SEND and BIST one cycle later, for as long as those are held.
	always_ff @(posedge CLK_SYS) begin
		EVT      <= (RSTN && SEND) ? FRAME : '0;
		BIST_ACT <= RSTN && BIST;
	end

	// A relink drops the link for a few cycles; the cause is not modelled,
	// so power management and COMRESET recoveries look alike here.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) down_ff <= 2'h0;
		else if (RELINK) down_ff <= 2'h2;
		else if (down_ff != 2'h0) down_ff <= down_ff - 2'h1;
	end

	// Link comes up after power-on and after every drop.
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) LINK_UP <= 1'b0;
		else LINK_UP <= (down_ff == 2'h0) && !RELINK;
	end
endmodule : pecl_host_model

/* sim/tb.sv */
// Self-checking bench for the link event counter log.
`timescale 1ns/1ps
module tb import pecl_pkg::*;;
	logic        CLK_SYS = 1'b0;
	logic        RSTN    = 1'b0;
	logic [11:0] PADDR   = 12'h000;
	logic        PSEL    = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE  = 1'b0;
	logic [31:0] PWDATA  = 32'h0000_0000;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	pecl_evt_s   EVT;
	logic        LINK_UP;
	logic        BIST_ACT;
	logic        LOG_REQ = 1'b0;
	logic        LOG_CLR = 1'b0;
	logic        LOG_BUSY;
	logic        LOG_DONE;
	logic        SEND    = 1'b0;
	pecl_evt_s   FRAME   = '0;
	logic        BIST    = 1'b0;
	logic        RELINK  = 1'b0;
	int          fail_count = 0;
	int          samples_checked = 0;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  pg [512];
	logic [7:0]  got [512];
	logic [15:0] pid;
	int          pos;
	int          nent;
	logic [7:0]  sum;
	logic [47:0] ent;
	logic [31:0] snap = 32'h01F3_0001;
	// Frame outcome beside the expected count of each counter, one nibble
	// each, counter 004h lowest.
	logic [36:0] rows [8] = '{
		{5'b11100, 32'h0100_0001}, {5'b11000, 32'h1000_0001},
		{5'b10100, 32'h0100_1010}, {5'b10000, 32'h1000_1010},
		{5'b00010, 32'h0000_0110}, {5'b10010, 32'h1000_1120},
		{5'b00001, 32'h0010_0000}, {5'b00100, 32'h0000_0000}};
	// Refused accesses: write flag beside the address.
	logic [12:0] bad [4] = '{13'h0200, 13'h0100, 13'h0002, 13'h1204};

	pecl_counter_log #(.CNT_W(4)) pecl_counter_log_i (.CLK_SYS(CLK_SYS),
		.RSTN(RSTN), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .EVT(EVT), .LINK_UP(LINK_UP),
		.BIST_ACT(BIST_ACT), .LOG_REQ(LOG_REQ), .LOG_CLR(LOG_CLR),
		.LOG_BUSY(LOG_BUSY), .LOG_DONE(LOG_DONE));
	pecl_host_model pecl_host_model_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
		.SEND(SEND), .FRAME(FRAME), .BIST(BIST), .RELINK(RELINK),
		.EVT(EVT), .LINK_UP(LINK_UP), .BIST_ACT(BIST_ACT));

	// Free-running system clock, 8 ns period.
	initial begin
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	task automatic close_out();
		$display("Mismatches %0d of %0d checks", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	// One APB transfer; the request holds until ready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge CLK_SYS);
		PSEL    <= 1'b1;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [11:0] a, input logic [31:0] want);
		apb(1'b0, a, 32'h0000_0000);
		check($sformatf("read %h", a), rd, want);
	endtask : rdchk

	task automatic cnts(input logic [31:0] e);
		for (int i = 0; i < PECL_NCNT; i++)
			rdchk(PECL_A_CNT + 12'(4 * i), {28'h000_0000, e[4*i +: 4]});
	endtask : cnts

	task automatic fire(input pecl_evt_s f, input logic b);
		@(posedge CLK_SYS);
		SEND  <= 1'b1;
		FRAME <= f;
		BIST  <= b;
		@(posedge CLK_SYS);
		SEND  <= 1'b0;
		BIST  <= 1'b0;
	endtask : fire

	// Main sequence: table of frame outcomes, then the awkward cases.
	initial begin
		repeat (16) @(posedge CLK_SYS);
		RSTN <= 1'b1;
		rdchk(PECL_A_STAT, 32'h0000_0000);
		cnts(32'h0001_0000);
		foreach (rows[k]) begin
			apb(1'b1, PECL_A_CTRL, 32'h0000_0004);
			fire(pecl_evt_s'(rows[k][36:32]), 1'b0);
			cnts(rows[k][31:0]);
		end
		apb(1'b1, PECL_A_CTRL, 32'h0000_0004);
		repeat (3) begin
			@(posedge CLK_SYS);
			RELINK <= 1'b1;
			@(posedge CLK_SYS);
			RELINK <= 1'b0;
			repeat (4) @(posedge CLK_SYS);
		end
		repeat (20) fire(pecl_evt_s'(5'b00001), 1'b0);
		fire(pecl_evt_s'(5'b11100), 1'b0);
		cnts(snap);
		@(posedge CLK_SYS);
		LOG_REQ <= 1'b1;
		LOG_CLR <= 1'b1;
		@(posedge CLK_SYS);
		LOG_REQ <= 1'b0;
		LOG_CLR <= 1'b0;
		foreach (bad[k]) begin
			apb(bad[k][12], bad[k][11:0], 32'h0000_0000);
			check("slave error", 32'(er), 32'h0000_0001);
		end
		// The build is still running here, so busy shows on pin and STAT.
		check("log busy", 32'(LOG_BUSY), 32'h0000_0001);
		rdchk(PECL_A_STAT, 32'h0000_0001);
		do @(posedge CLK_SYS); while (LOG_DONE !== 1'b1);
		cnts(32'h0000_0000);
		rdchk(PECL_A_STAT, 32'h0000_0002);
		pg = '{default: 8'h00};
		sum = 8'h00;
		for (int i = 0; i < PECL_NCNT; i++) begin
			ent[15:0] = PECL_IDS[i];
			ent[47:16] = (snap[4*i +: 4] == 4'hF) ? 32'hFFFF_FFFF
				: {28'h000_0000, snap[4*i +: 4]};
			for (int b = 0; b < 6; b++)
				pg[4 + 6*i + b] = ent[8*b +: 8];
		end
		for (int i = 0; i < 511; i++)
			sum = sum + pg[i];
		pg[511] = 8'h00 - sum;
		for (int w = 0; w < 128; w++) begin
			rdchk(PECL_A_PAGE + 12'(4 * w), {pg[4*w+3], pg[4*w+2],
				pg[4*w+1], pg[4*w]});
			{got[4*w+3], got[4*w+2], got[4*w+1], got[4*w]} = rd;
		end
		// Walk the page read back as the host does: stop at a zero
		// identifier or at the end of the page.
		pos  = 4;
		nent = 0;
		while (pos < 510) begin
			pid = {got[pos+1], got[pos]};
			if (pid == 16'h0000) break;
			pos = pos + 2 + 2 * int'(pid[14:12]);
			nent++;
		end
		check("entries parsed", 32'(nent), 32'(PECL_NCNT));
		check("end marker", 32'(pos), 32'h0000_0034);
		fire(pecl_evt_s'(5'b11100), 1'b0);
		fire(pecl_evt_s'(5'b00001), 1'b1);
		cnts(32'h0010_0000);
		apb(1'b1, PECL_A_CTRL, 32'h0000_0002);
		rdchk(PECL_A_CTRL, 32'h0000_0002);
		// Software build with the stored clear flag: old values on the
		// page, counters zero afterwards.
		apb(1'b1, PECL_A_CTRL, 32'h0000_0003);
		do @(posedge CLK_SYS); while (LOG_DONE !== 1'b1);
		cnts(32'h0000_0000);
		rdchk(PECL_A_PAGE + 12'h024, 32'h0000_0001);
		rdchk(PECL_A_CTRL, 32'h0000_0002);
		close_out();
	end

	// Watchdog: the whole run needs about 2400 cycles.
	initial begin
		#200_000;
		fail_count++;
		close_out();
	end
endmodule : tb

bind pecl_counter_log pecl_chk pecl_chk_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .LOG_REQ(LOG_REQ), .LOG_BUSY(LOG_BUSY),
	.LOG_DONE(LOG_DONE));
